// ==== ipma_ctrl.sv ====
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module ipma_ctrl
    import ipma_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // avalon-mm slave
    input  wire logic [ipma_pkg::ADDR_W-1:0] address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [ipma_pkg::DATA_W-1:0] writedata,
    input  wire logic [ipma_pkg::BE_W-1:0]   byteenable,
    output logic      [ipma_pkg::DATA_W-1:0] readdata,
    output logic                         waitrequest,
    // internal sources, same clock: dma3..0, serial1..0, i2c, timer2..1, watchdog
    input  wire logic [ipma_pkg::NUM_INT-1:0] internalSourceReq,
    // external request pins, active low, asynchronous
    input  wire logic                    extRequestPinSeven_n,
    input  wire logic                    extRequestPinFiveFour_n,
    input  wire logic                    extRequestPinThreeSix_n,
    input  wire logic                    extRequestPinOneTwo_n,
    // core side
    output logic      [2:0]              coreIrqLevel,
    output logic      [4:0]              coreIrqSource,
    input  wire logic                    iackStrobe,
    input  wire logic [2:0]              iackLevel,
    output logic                         ackDone,
    output logic                         ackAutovector,
    output logic      [7:0]              ackVectorOffset,
    output logic                         addressStrobeBlock,
    // event interrupt
    output logic                         irq
);
    import ipma_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rstMeta_reg;
    logic rstSync_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_n   <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_n   <= rstMeta_reg;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pinMeta_reg;
    logic [3:0] pinSync_reg;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinMeta_reg <= 4'h0;
            pinSync_reg <= 4'h0;
        end else begin
            pinMeta_reg <= {~extRequestPinSeven_n, ~extRequestPinFiveFour_n,
                            ~extRequestPinThreeSix_n, ~extRequestPinOneTwo_n};
            pinSync_reg <= pinMeta_reg;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [SRC_W-1:0] pendingSources_reg;
    logic [SRC_W-1:0] sourceMasks_reg;
    logic [7:0]       extAutovectorCtrl_reg;
    logic [7:0]       pinLevelAssign_reg;
    logic [7:0]       sourceControl_reg [NUM_INT];
    logic [SRC_W-1:0] evtStatus_reg;
    logic [SRC_W-1:0] evtMask_reg;
    logic [7:0]       levelEnable;
    logic [SRC_W-1:0] pendingSources_next;

    assign levelEnable = enabledLevels(pinLevelAssign_reg);

    // ----------------------------------------------------------------
    // pending capture
    // ----------------------------------------------------------------
    always_comb begin
        pendingSources_next                          = '0;
        pendingSources_next[INT_BASE +: NUM_INT]     = internalSourceReq;
        pendingSources_next[EXT_TOP_LEVEL]           = pinSync_reg[3];
        pendingSources_next[5] = pinSync_reg[2] & levelEnable[5];
        pendingSources_next[4] = pinSync_reg[2] & levelEnable[4];
        pendingSources_next[3] = pinSync_reg[1] & levelEnable[3];
        pendingSources_next[6] = pinSync_reg[1] & levelEnable[6];
        pendingSources_next[1] = pinSync_reg[0] & levelEnable[1];
        pendingSources_next[2] = pinSync_reg[0] & levelEnable[2];
    end

    // mask does not gate capture, so masked sources still show pending
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pendingSources_reg <= '0;
        end else begin
            pendingSources_reg <= pendingSources_next;
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    ipma_bus_state_t  busState_reg;
    logic             wrFire;
    logic [7:0]       wordOff;
    logic [DATA_W-1:0] readValue;

    // one wait cycle, then the request completes
    assign waitrequest = (read | write) & (busState_reg == BUS_IDLE);
    assign wrFire      = write & ~waitrequest;
    assign wordOff     = {address[ADDR_W-1:WORD_SHIFT], 2'b00};

    function automatic logic [DATA_W-1:0] mergeBytes(
        input logic [DATA_W-1:0] oldV,
        input logic [DATA_W-1:0] newV,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] r;
        r = oldV;
        for (int b = 0; b < BE_W; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = newV[b*8 +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    function automatic logic isSrcCtrl(input logic [7:0] off, output logic [3:0] idx);
        logic [7:0] rel;
        rel = off - OFF_SRC_CTRL0;
        idx = rel[WORD_SHIFT +: 4];
        return (off >= OFF_SRC_CTRL0) && (rel[7:WORD_SHIFT] < 6'(NUM_INT));
    endfunction : isSrcCtrl

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busState_reg <= BUS_IDLE;
        end else begin
            unique case (busState_reg)
                BUS_IDLE: begin
                    if (read | write) begin
                        busState_reg <= BUS_DONE;
                    end
                end
                BUS_DONE: begin
                    busState_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    // reserved and unmapped words read as zero
    always_comb begin
        logic [3:0] idx;
        idx       = 4'h0;
        readValue = '0;
        if (isSrcCtrl(wordOff, idx)) begin
            readValue[7:0] = sourceControl_reg[idx];
        end else begin
            unique case (wordOff)
                OFF_PENDING:   readValue[SRC_W-1:0] = pendingSources_reg;
                OFF_MASK:      readValue[SRC_W-1:0] = sourceMasks_reg;
                OFF_AUTOVECTOR_SELECT_CTRL: readValue[7:0]       = extAutovectorCtrl_reg;
                OFF_PIN_LEVEL: readValue[7:0]       = pinLevelAssign_reg;
                OFF_EVT_STAT:  readValue[SRC_W-1:0] = evtStatus_reg;
                OFF_EVT_MASK:  readValue[SRC_W-1:0] = evtMask_reg;
                default:       readValue            = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            readdata <= '0;
        end else if (read && busState_reg == BUS_IDLE) begin
            readdata <= readValue;
        end
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sourceMasks_reg <= MASK_RESET;
        end else if (wrFire && wordOff == OFF_MASK) begin
            sourceMasks_reg <= SRC_W'(mergeBytes(DATA_W'(sourceMasks_reg), writedata,
                                                 byteenable)) & SRC_VALID;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            extAutovectorCtrl_reg <= AUTOVECTOR_SELECT_RESET;
        end else if (wrFire && wordOff == OFF_AUTOVECTOR_SELECT_CTRL && byteenable[0]) begin
            extAutovectorCtrl_reg <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinLevelAssign_reg <= PIN_RESET;
        end else if (wrFire && wordOff == OFF_PIN_LEVEL && byteenable[0]) begin
            pinLevelAssign_reg <= writedata[7:0] & PIN_USED;
        end
    end

    generate
        for (genvar g = 0; g < NUM_INT; g++) begin : gSrcCtrl
            localparam logic [7:0] MY_OFF = OFF_SRC_CTRL0 + 8'(g << WORD_SHIFT);
            always_ff @(posedge clk or negedge rstSync_n) begin
                if (!rstSync_n) begin
                    sourceControl_reg[g] <= SC_RESET;
                end else if (wrFire && wordOff == MY_OFF && byteenable[0]) begin
                    sourceControl_reg[g] <= writedata[7:0] & SC_USED;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // ranking
    // ----------------------------------------------------------------
    ipma_rank_if rankBus ();
    logic [SRC_W-1:0] activeSources;

    assign activeSources = pendingSources_reg & ~sourceMasks_reg & SRC_VALID;

    always_comb begin
        rankBus.candValid = '0;
        for (int i = 0; i < SRC_W; i++) begin
            rankBus.candKey[i] = '0;
        end
        // external pins take the middle slot of their level
        for (int l = SRC_LO; l <= EXT_TOP_LEVEL; l++) begin
            rankBus.candValid[l] = activeSources[l];
            rankBus.candKey[l]   = {3'(l), EXT_SUB};
        end
        for (int s = 0; s < NUM_INT; s++) begin
            rankBus.candKey[INT_BASE+s] =
                {sourceControl_reg[s][SC_LVL_HI:SC_LVL_LO],
                 internalSub(sourceControl_reg[s][SC_PRI_HI:SC_PRI_LO])};
            // level zero never requests
            rankBus.candValid[INT_BASE+s] = activeSources[INT_BASE+s] &&
                (sourceControl_reg[s][SC_LVL_HI:SC_LVL_LO] != LVL_NONE);
        end
    end

    ipma_rank uRank (
        .rk (rankBus.ranker)
    );

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            coreIrqLevel  <= LVL_NONE;
            coreIrqSource <= '0;
        end else begin
            coreIrqLevel  <= rankBus.winValid ? rankBus.winLevel : LVL_NONE;
            coreIrqSource <= rankBus.winValid ? rankBus.winIdx : 5'h00;
        end
    end

    // ----------------------------------------------------------------
    // acknowledge cycle answer
    // ----------------------------------------------------------------
    logic       winInternal;
    logic [3:0] winIntIdx;
    logic       ackAvecNext;

    assign winInternal = coreIrqSource >= 5'(INT_BASE);
    assign winIntIdx   = 4'(coreIrqSource - 5'(INT_BASE));

    always_comb begin
        if (winInternal && coreIrqLevel == iackLevel && iackLevel != LVL_NONE) begin
            ackAvecNext = sourceControl_reg[winIntIdx][SC_AUTOVECTOR_SELECT_BIT];
        end else begin
            // disregarded unless a pin drives this level
            ackAvecNext = extAutovectorCtrl_reg[iackLevel] & levelEnable[iackLevel] &
                          (iackLevel != LVL_NONE);
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ackDone            <= 1'b0;
            ackAutovector      <= 1'b0;
            ackVectorOffset    <= 8'h00;
            addressStrobeBlock <= 1'b0;
        end else begin
            ackDone <= iackStrobe;
            if (iackStrobe) begin
                ackAutovector      <= ackAvecNext;
                ackVectorOffset    <= VEC_BASE + {3'h0, iackLevel, 2'b00};
                addressStrobeBlock <= ackAvecNext &
                                      extAutovectorCtrl_reg[AUTOVECTOR_SELECT_BLK_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // event status: rising pending edges, write one to clear
    // ----------------------------------------------------------------
    logic [SRC_W-1:0] evtRise;
    logic [SRC_W-1:0] evtClear;

    assign evtRise  = pendingSources_next & ~pendingSources_reg & SRC_VALID;
    assign evtClear = (wrFire && wordOff == OFF_EVT_STAT) ?
                      SRC_W'(mergeBytes('0, writedata, byteenable)) : '0;

    // set beats clear so an edge in the clearing cycle survives
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            evtStatus_reg <= '0;
        end else begin
            evtStatus_reg <= (evtStatus_reg & ~evtClear) | evtRise;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            evtMask_reg <= '0;
        end else if (wrFire && wordOff == OFF_EVT_MASK) begin
            evtMask_reg <= SRC_W'(mergeBytes(DATA_W'(evtMask_reg), writedata,
                                             byteenable)) & SRC_VALID;
        end
    end

    assign irq = |(evtStatus_reg & evtMask_reg);

endmodule : ipma_ctrl

// ==== ipma_pkg.sv ====
package ipma_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          BE_W          = 4;
    localparam logic [7:0]  OFF_PENDING   = 8'h40;
    localparam logic [7:0]  OFF_MASK      = 8'h44;
    localparam logic [7:0]  OFF_AUTOVECTOR_SELECT_CTRL = 8'h48;
    localparam logic [7:0]  OFF_PIN_LEVEL = 8'h4C;
    localparam logic [7:0]  OFF_SRC_CTRL0 = 8'h50;
    localparam logic [7:0]  OFF_EVT_STAT  = 8'h78;
    localparam logic [7:0]  OFF_EVT_MASK  = 8'h7C;
    localparam int          WORD_SHIFT    = 2;

    // ----------------------------------------------------------------
    // source layout
    // ----------------------------------------------------------------
    localparam int          SRC_W         = 18;
    localparam int          SRC_LO        = 1;
    localparam int          SRC_HI        = 17;
    localparam int          NUM_INT       = 10;
    localparam int          INT_BASE      = 8;
    localparam int          EXT_TOP_LEVEL = 7;
    localparam logic [17:0] MASK_RESET    = 18'h3FFFE;
    localparam logic [17:0] SRC_VALID     = 18'h3FFFE;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          AUTOVECTOR_SELECT_BLK_BIT  = 0;
    localparam int          PIN54_BIT     = 7;
    localparam int          PIN36_BIT     = 6;
    localparam int          PIN12_BIT     = 5;
    localparam int          SC_AUTOVECTOR_SELECT_BIT   = 7;
    localparam int          SC_LVL_HI     = 4;
    localparam int          SC_LVL_LO     = 2;
    localparam int          SC_PRI_HI     = 1;
    localparam int          SC_PRI_LO     = 0;
    localparam logic [7:0]  AUTOVECTOR_SELECT_RESET    = 8'h00;
    localparam logic [7:0]  PIN_RESET     = 8'h00;
    localparam logic [7:0]  SC_RESET      = 8'h00;
    localparam logic [7:0]  PIN_USED      = 8'hE0;
    localparam logic [7:0]  SC_USED       = 8'h9F;

    // ----------------------------------------------------------------
    // ranking and vectors
    // ----------------------------------------------------------------
    localparam logic [2:0]  EXT_SUB       = 3'h2;
    localparam logic [2:0]  LVL_NONE      = 3'h0;
    localparam logic [7:0]  VEC_BASE      = 8'h60;

    typedef logic [5:0] ipma_key_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } ipma_bus_state_t;

    // levels 7..1 that the external pins currently drive
    function automatic logic [7:0] enabledLevels(input logic [7:0] pla);
        logic [7:0] en;
        en                = 8'h00;
        en[EXT_TOP_LEVEL] = 1'b1;
        en[5]             = ~pla[PIN54_BIT];
        en[4]             =  pla[PIN54_BIT];
        en[3]             = ~pla[PIN36_BIT];
        en[6]             =  pla[PIN36_BIT];
        en[1]             = ~pla[PIN12_BIT];
        en[2]             =  pla[PIN12_BIT];
        return en;
    endfunction : enabledLevels

    // internal priority 11,10 above the pin, 01,00 below it
    function automatic logic [2:0] internalSub(input logic [1:0] pri);
        return pri[1] ? ({1'b0, pri} + 3'h1) : {1'b0, pri};
    endfunction : internalSub

endpackage : ipma_pkg

// ==== ipma_rank_if.sv ====
`timescale 1ns/1ps
interface ipma_rank_if;
    import ipma_pkg::*;
    logic [SRC_W-1:0] candValid;
    ipma_key_t        candKey [SRC_W];
    logic             winValid;
    logic [2:0]       winLevel;
    logic [4:0]       winIdx;

    modport requester (output candValid, output candKey,
                       input winValid, input winLevel, input winIdx);
    modport ranker    (input candValid, input candKey,
                       output winValid, output winLevel, output winIdx);
endinterface : ipma_rank_if

// ==== ipma_rank.sv ====
`timescale 1ns/1ps
module ipma_rank (
    ipma_rank_if.ranker rk
);
    import ipma_pkg::*;

    // ----------------------------------------------------------------
    // highest key wins; equal keys are a software error, lowest index kept
    // ----------------------------------------------------------------
    always_comb begin
        ipma_key_t best;
        best        = '0;
        rk.winValid = 1'b0;
        rk.winLevel = LVL_NONE;
        rk.winIdx   = '0;
        for (int i = SRC_LO; i <= SRC_HI; i++) begin
            if (rk.candValid[i] && (!rk.winValid || rk.candKey[i] > best)) begin
                best        = rk.candKey[i];
                rk.winValid = 1'b1;
                rk.winLevel = rk.candKey[i][5:3];
                rk.winIdx   = 5'(i);
            end
        end
    end

endmodule : ipma_rank

// ==== ipma_checker.sv ====
`timescale 1ns/1ps
module ipma_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [2:0]  coreIrqLevel,
    input wire logic [4:0]  coreIrqSource,
    input wire logic        iackStrobe,
    input wire logic [2:0]  iackLevel,
    input wire logic        ackDone,
    input wire logic        ackAutovector,
    input wire logic [7:0]  ackVectorOffset,
    input wire logic        addressStrobeBlock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ack_next; iackStrobe |=> ackDone; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not answered");
    property p_ack_cause; ackDone |-> $past(iackStrobe); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
    property p_offset; iackStrobe && iackLevel != 3'h0 |=> ackVectorOffset == 8'h60 +
        {3'h0, $past(iackLevel), 2'h0}; endproperty
    a_offset: assert property (p_offset) else $error("vector offset wrong");
    property p_blk; ackDone && !ackAutovector |-> !addressStrobeBlock; endproperty
    a_blk: assert property (p_blk) else $error("strobe blocked outside autovector");
    property p_hold; !iackStrobe |=> $stable({ackAutovector, ackVectorOffset,
        addressStrobeBlock}); endproperty
    a_hold: assert property (p_hold) else $error("ack result changed");
    property p_none; (coreIrqLevel == 3'h0) == (coreIrqSource == 5'h0); endproperty
    a_none: assert property (p_none) else $error("level and source disagree");
    property p_pin; coreIrqSource inside {[5'h1:5'h7]} |-> coreIrqLevel == coreIrqSource[2:0];
    endproperty
    a_pin: assert property (p_pin) else $error("pin source at wrong level");
    property p_range; coreIrqSource <= 5'h11; endproperty
    a_range: assert property (p_range) else $error("source index out of range");
    property p_rsv; read && !waitrequest && address inside {8'h40, 8'h44} |->
        readdata[31:18] == 14'h0 && !readdata[0]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    c_autovector_select: cover property (ackDone && ackAutovector);
    c_lvl7: cover property (coreIrqLevel == 3'h7);
    c_int: cover property (coreIrqSource > 5'h7);
endmodule : ipma_checker

// ==== ipma_core_model.sv ====
`timescale 1ns/1ps
module ipma_core_model (
    input wire logic  clk,
    input wire logic  ackDone,
    output logic      iackStrobe,
    output logic[2:0] iackLevel
);
    initial begin
        iackStrobe = 1'b0;
        iackLevel  = 3'h0;
    end
    // dly lets the core answer promptly or late
    task automatic ack(input logic [2:0] lv, input int dly, output logic ok);
        int n;
        n = 0;
        repeat (dly + 1) @(posedge clk);
        iackStrobe <= 1'b1;
        iackLevel  <= lv;
        @(posedge clk);
        iackStrobe <= 1'b0;
        iackLevel  <= ~lv; // level no longer qualified: driven to ~lv, still a nonzero level for lv below 7
        do begin
            @(posedge clk);
            n++;
        end while (ackDone !== 1'b1 && n < 8);
        ok = (ackDone === 1'b1);
    endtask : ack
endmodule : ipma_core_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import ipma_pkg::*;
    logic        clk, arst_n, read, write, iackStrobe, ackDone, ackAutovector, ok;
    logic        waitrequest, addressStrobeBlock, irq;
    logic [7:0]  address, ackVectorOffset;
    logic [31:0] writedata, readdata, q;
    logic [9:0]  isr;
    logic [3:0]  pins_n;
    logic [2:0]  coreIrqLevel, iackLevel;
    logic [4:0]  coreIrqSource;
    int          err_total, compares;
    ipma_ctrl dut (.clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .internalSourceReq(isr), .extRequestPinSeven_n(pins_n[3]),
        .extRequestPinFiveFour_n(pins_n[2]), .extRequestPinThreeSix_n(pins_n[1]),
        .extRequestPinOneTwo_n(pins_n[0]), .coreIrqLevel(coreIrqLevel),
        .coreIrqSource(coreIrqSource), .iackStrobe(iackStrobe), .iackLevel(iackLevel),
        .ackDone(ackDone), .ackAutovector(ackAutovector), .ackVectorOffset(ackVectorOffset),
        .addressStrobeBlock(addressStrobeBlock), .irq(irq));
    ipma_core_model core (.clk(clk), .ackDone(ackDone), .iackStrobe(iackStrobe),
        .iackLevel(iackLevel));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        read      <= ~wr;
        write     <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 16);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (n >= 16) err_total++;
    endtask : bus
    task automatic t_mask;
        bus(1'b0, OFF_MASK, 32'h0);
        chk("mask reset", 32'h0003FFFE, q);
        bus(1'b1, OFF_PENDING, 32'h0003FFFE);
        bus(1'b0, 8'hF0, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, OFF_SRC_CTRL0, 32'h0000000C);
        isr <= 10'h001;
        repeat (4) @(posedge clk);
        bus(1'b0, OFF_PENDING, 32'h0);
        chk("pend wdog", 32'h00000100, q);
        chk("masked", 32'h0, {29'h0, coreIrqLevel});
        // core mask level is taken as raised before any mask changes
        bus(1'b1, OFF_MASK, 32'h0003FEFE);
        repeat (3) @(posedge clk);
        chk("unmasked", 32'h43, {24'h0, coreIrqSource, coreIrqLevel});
        isr <= 10'h200;
        repeat (3) @(posedge clk);
        bus(1'b0, OFF_PENDING, 32'h0);
        chk("pend dma3", 32'h00020000, q);
        $display("end mask");
    endtask : t_mask
    task automatic t_rank;
        logic [7:0] pla [6] = '{8'h80, 8'h00, 8'h00, 8'h40, 8'h20, 8'h00};
        int         pin [6] = '{2, 2, 1, 1, 0, 0};
        logic [2:0] lv  [6] = '{3'h4, 3'h5, 3'h3, 3'h6, 3'h2, 3'h1};
        bus(1'b1, OFF_MASK, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, OFF_PIN_LEVEL, {24'h0, pla[i]});
            bus(1'b1, OFF_SRC_CTRL0 + 8'h4, {27'h0, lv[i], 2'h2});
            bus(1'b1, OFF_SRC_CTRL0 + 8'h8, {27'h0, lv[i], 2'h1});
            isr <= 10'h006;
            pins_n[pin[i]] <= 1'b0;
            repeat (6) @(posedge clk);
            chk("rank hi", {24'h0, 5'd9, lv[i]}, {24'h0, coreIrqSource, coreIrqLevel});
            isr <= 10'h004;
            repeat (3) @(posedge clk);
            chk("rank pin", {26'h0, lv[i], lv[i]}, {24'h0, coreIrqSource, coreIrqLevel});
            pins_n <= 4'hF;
            repeat (6) @(posedge clk);
            chk("rank lo", {24'h0, 5'd10, lv[i]}, {24'h0, coreIrqSource, coreIrqLevel});
            isr <= 10'h000;
        end
        $display("end rank");
    endtask : t_rank
    task automatic t_autovector_select;
        logic [7:0] external_autovector_control [3] = '{8'hFF, 8'hFE, 8'h00};
        logic       av;
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 3; a++) begin
                bus(1'b1, OFF_PIN_LEVEL, (p == 1) ? 32'hE0 : 32'h0);
                bus(1'b1, OFF_AUTOVECTOR_SELECT_CTRL, {24'h0, external_autovector_control[a]});
                for (int l = 1; l < 8; l++) begin
                    core.ack(3'(l), a, ok);
                    av = external_autovector_control[a][l] & ((l == 7) || ((l % 2 == 1) == (p == 0)));
                    chk("done", 32'h1, {31'h0, ok});
                    chk("autovector_select", {31'h0, av}, {31'h0, ackAutovector});
                    chk("offset", 32'h60 + 32'(4 * l), {24'h0, ackVectorOffset});
                    chk("block", {31'h0, av & external_autovector_control[a][0]}, {31'h0, addressStrobeBlock});
                end
            end
        end
        bus(1'b1, OFF_AUTOVECTOR_SELECT_CTRL, 32'h01);
        bus(1'b1, OFF_SRC_CTRL0, 32'h8C);
        isr <= 10'h001;
        repeat (3) @(posedge clk);
        core.ack(3'h3, 0, ok);
        chk("int autovector_select", 32'h3, {30'h0, ackAutovector, addressStrobeBlock});
        bus(1'b1, OFF_SRC_CTRL0, 32'h0C);
        bus(1'b1, OFF_PIN_LEVEL, 32'h0);
        bus(1'b1, OFF_AUTOVECTOR_SELECT_CTRL, 32'h08);
        core.ack(3'h3, 1, ok);
        chk("int own", 32'h0, {30'h0, ackAutovector, addressStrobeBlock});
        $display("end autovector_select");
    endtask : t_autovector_select
    task automatic t_event;
        isr <= 10'h000;
        bus(1'b1, OFF_EVT_STAT, 32'h0003FFFE);
        bus(1'b1, OFF_EVT_MASK, 32'h00000100);
        chk("irq idle", 32'h0, {31'h0, irq});
        isr <= 10'h001;
        repeat (3) @(posedge clk);
        chk("irq set", 32'h1, {31'h0, irq});
        bus(1'b0, OFF_EVT_STAT, 32'h0);
        chk("status", 32'h00000100, q);
        bus(1'b1, OFF_EVT_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, OFF_EVT_MASK, 32'h00000100);
        isr <= 10'h000;
        bus(1'b1, OFF_EVT_STAT, 32'h00000100);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("end event");
    endtask : t_event
    task automatic close_out;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    initial begin
        {arst_n, read, write, address, writedata, isr} = '0;
        pins_n    = 4'hF;
        err_total = 0;
        compares  = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_mask;
        t_rank;
        t_autovector_select;
        t_event;
        close_out;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        close_out;
    end
endmodule : testbench
bind ipma_ctrl ipma_checker chk_i (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .readdata(readdata), .waitrequest(waitrequest), .coreIrqLevel(coreIrqLevel),
    .coreIrqSource(coreIrqSource), .iackStrobe(iackStrobe), .iackLevel(iackLevel),
    .ackDone(ackDone), .ackAutovector(ackAutovector), .ackVectorOffset(ackVectorOffset),
    .addressStrobeBlock(addressStrobeBlock));
